/* hdl/bec_pkg.sv */
// Constants and state encoding for the bridge excitation chopper.
// Assumes a single 25 MHz clock shared by every user of this package.
package bec_pkg;
    localparam int READ_W = 24;
    localparam int CLK_PERIOD_NS = 40;
    // Shortest time with both switch pairs off at a phase change
    localparam int NONOVERLAP_NS = 1000;
    localparam int NONOVERLAP_CYC_INT = (NONOVERLAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CNT_W = 5;
    localparam logic [GAP_CNT_W-1:0] NONOVERLAP_CYC = GAP_CNT_W'(NONOVERLAP_CYC_INT);
    localparam logic [GAP_CNT_W-1:0] GAP_CNT_ZERO = 5'h00;
    localparam logic [GAP_CNT_W-1:0] GAP_CNT_ONE = 5'h01;

    // Reset value of the drive pins: forward polarity applied
    localparam logic FWD_DRIVE_RST = 1'h1;
    localparam logic FWD_DRIVE_N_RST = 1'h0;
    localparam logic REV_DRIVE_RST = 1'h0;
    localparam logic REV_DRIVE_N_RST = 1'h1;

    typedef enum logic [2:0] {
        BEC_IDLE = 3'h0,
        BEC_FWD = 3'h4,
        BEC_GAP_R = 3'h5,
        BEC_REV = 3'h7,
        BEC_GAP_F = 3'h6
    } bec_state_e;
endpackage

/* hdl/bec_phase_store.sv */
// One-word store for the reading of the previous phase.
// Assumes the writer holds write data stable only in the write cycle.
module bec_phase_store
    import bec_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic write_en_in,
    input wire logic [READ_W-1:0] write_data_in,
    output logic [READ_W-1:0] read_data_out
);
    logic [READ_W-1:0] word_reg;
    logic [READ_W-1:0] word_next;

    always_comb begin
        word_next = word_reg;
        if (write_en_in) begin
            word_next = write_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            word_reg <= 24'h000000;
        end else begin
            word_reg <= word_next;
        end
    end

    // Read data straight from the register: the old word during a write
    assign read_data_out = word_reg;
endmodule

/* hdl/bec_chopper.sv */
// Excitation chopping sequencer: drives four switch-control pins and
// combines forward and reverse readings into offset-free results.
// Assumes conv_done_in pulses once per conversion with reading_in valid.
module bec_chopper
    import bec_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic chop_enable_in,
    input wire logic conv_done_in,
    input wire logic [READ_W-1:0] reading_in,
    output logic fwd_phase_drive_out,
    output logic fwd_phase_drive_n_out,
    output logic rev_phase_drive_out,
    output logic rev_phase_drive_n_out,
    output logic ref_swap_out,
    output logic [READ_W-1:0] result_out,
    output logic result_valid_out
);
    function automatic logic [READ_W-1:0] halve_diff(input logic [READ_W-1:0] a,
                                                     input logic [READ_W-1:0] b);
        logic [READ_W:0] d;
        d = {a[READ_W-1], a} - {b[READ_W-1], b};
        return d[READ_W:1];
    endfunction

    bec_state_e state_reg;
    bec_state_e state_next;
    logic [GAP_CNT_W-1:0] gap_cnt_reg;
    logic [GAP_CNT_W-1:0] gap_cnt_next;
    logic pair_valid_reg;
    logic pair_valid_next;
    logic fwd_reg;
    logic fwd_next;
    logic fwd_n_reg;
    logic fwd_n_next;
    logic rev_reg;
    logic rev_next;
    logic rev_n_reg;
    logic rev_n_next;
    logic swap_reg;
    logic swap_next;
    logic [READ_W-1:0] result_reg;
    logic [READ_W-1:0] result_next;
    logic result_valid_reg;
    logic result_valid_next;
    logic take_reading;
    logic [READ_W-1:0] prev_reading;

    // Readings taken while both pairs are off are unsettled and dropped
    assign take_reading = chop_enable_in && conv_done_in &&
                          (state_reg == BEC_FWD || state_reg == BEC_REV);

    bec_phase_store u_store (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .write_en_in(take_reading),
        .write_data_in(reading_in),
        .read_data_out(prev_reading)
    );

    always_comb begin
        state_next = state_reg;
        gap_cnt_next = gap_cnt_reg;
        case (state_reg)
            BEC_IDLE: begin
                if (chop_enable_in) begin
                    state_next = BEC_FWD;
                end
            end
            BEC_FWD: begin
                if (conv_done_in) begin
                    state_next = BEC_GAP_R;
                    gap_cnt_next = GAP_CNT_ZERO;
                end
            end
            BEC_GAP_R: begin
                gap_cnt_next = gap_cnt_reg + GAP_CNT_ONE;
                if (gap_cnt_reg == NONOVERLAP_CYC - GAP_CNT_ONE) begin
                    state_next = BEC_REV;
                end
            end
            BEC_REV: begin
                if (conv_done_in) begin
                    state_next = BEC_GAP_F;
                    gap_cnt_next = GAP_CNT_ZERO;
                end
            end
            BEC_GAP_F: begin
                gap_cnt_next = gap_cnt_reg + GAP_CNT_ONE;
                if (gap_cnt_reg == NONOVERLAP_CYC - GAP_CNT_ONE) begin
                    state_next = BEC_FWD;
                end
            end
            default: begin
                state_next = BEC_IDLE;
            end
        endcase
        // Disabling in reverse still runs the full gap before forward returns
        if (!chop_enable_in) begin
            if (state_reg == BEC_REV) begin
                state_next = BEC_GAP_F;
                gap_cnt_next = GAP_CNT_ZERO;
            end else if (state_next != BEC_GAP_F) begin
                state_next = BEC_IDLE;
            end
        end
    end

    // Pins follow the next state so that every output comes from a flop
    always_comb begin
        fwd_next = 1'h0;
        fwd_n_next = 1'h1;
        rev_next = 1'h0;
        rev_n_next = 1'h1;
        case (state_next)
            BEC_IDLE, BEC_FWD: begin
                fwd_next = 1'h1;
                fwd_n_next = 1'h0;
            end
            BEC_REV: begin
                rev_next = 1'h1;
                rev_n_next = 1'h0;
            end
            default: begin
                fwd_next = 1'h0;
                fwd_n_next = 1'h1;
            end
        endcase
        swap_next = (state_next == BEC_REV);
    end

    always_comb begin
        pair_valid_next = pair_valid_reg;
        result_next = result_reg;
        result_valid_next = 1'h0;
        if (take_reading) begin
            pair_valid_next = 1'h1;
            if (pair_valid_reg) begin
                result_valid_next = 1'h1;
                if (state_reg == BEC_FWD) begin
                    result_next = halve_diff(reading_in, prev_reading);
                end else begin
                    result_next = halve_diff(prev_reading, reading_in);
                end
            end
        end
        // A dropped period breaks the pairing; restart the latency
        if (!chop_enable_in || (conv_done_in && !take_reading)) begin
            pair_valid_next = 1'h0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= BEC_IDLE;
            gap_cnt_reg <= GAP_CNT_ZERO;
            pair_valid_reg <= 1'h0;
            fwd_reg <= FWD_DRIVE_RST;
            fwd_n_reg <= FWD_DRIVE_N_RST;
            rev_reg <= REV_DRIVE_RST;
            rev_n_reg <= REV_DRIVE_N_RST;
            swap_reg <= 1'h0;
            result_reg <= 24'h000000;
            result_valid_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            gap_cnt_reg <= gap_cnt_next;
            pair_valid_reg <= pair_valid_next;
            fwd_reg <= fwd_next;
            fwd_n_reg <= fwd_n_next;
            rev_reg <= rev_next;
            rev_n_reg <= rev_n_next;
            swap_reg <= swap_next;
            result_reg <= result_next;
            result_valid_reg <= result_valid_next;
        end
    end

    assign fwd_phase_drive_out = fwd_reg;
    assign fwd_phase_drive_n_out = fwd_n_reg;
    assign rev_phase_drive_out = rev_reg;
    assign rev_phase_drive_n_out = rev_n_reg;
    assign ref_swap_out = swap_reg;
    assign result_out = result_reg;
    assign result_valid_out = result_valid_reg;

    // Helper: consecutive cycles with both pairs off at the pins
    logic [7:0] off_cnt_reg;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            off_cnt_reg <= 8'h00;
        end else if (!fwd_reg && !rev_reg) begin
            off_cnt_reg <= off_cnt_reg + 8'h01;
        end else begin
            off_cnt_reg <= 8'h00;
        end
    end

    no_shoot_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !(fwd_phase_drive_out && rev_phase_drive_out) &&
        (fwd_phase_drive_n_out || rev_phase_drive_n_out))
        else $error("both switch pairs enabled");

    gap_length_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ($rose(rev_phase_drive_out) ||
        ($rose(fwd_phase_drive_out) && $past(state_reg) == BEC_GAP_F))
        |-> off_cnt_reg == 8'(NONOVERLAP_CYC_INT))
        else $error("non-overlap gap has wrong length");

    fwd_levels_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == BEC_FWD) |-> fwd_phase_drive_out && !fwd_phase_drive_n_out)
        else $error("forward pair not driven in forward phase");

    fwd_rev_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == BEC_FWD) |-> !rev_phase_drive_out && rev_phase_drive_n_out)
        else $error("reverse pair active in forward phase");

    rev_levels_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == BEC_REV) |-> rev_phase_drive_out && !rev_phase_drive_n_out &&
        !fwd_phase_drive_out && fwd_phase_drive_n_out)
        else $error("wrong pin levels in reverse phase");

    rev_only_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == BEC_FWD) && conv_done_in && chop_enable_in |->
        ##[1:40] (rev_phase_drive_out && !fwd_phase_drive_out))
        else $error("reverse phase not reached after forward");

    ref_swap_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ref_swap_out == (rev_phase_drive_out && !rev_phase_drive_n_out))
        else $error("reference swap out of step with reverse phase");

    phase_rate_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ($fell(fwd_phase_drive_out) || $fell(rev_phase_drive_out)) && $past(chop_enable_in)
        |-> $past(conv_done_in))
        else $error("polarity changed without a conversion");

    result_fwd_a: assert property (@(posedge clk_in) disable iff (rst_in)
        result_valid_out && $past(state_reg) == BEC_FWD |->
        result_out == halve_diff($past(reading_in), $past(prev_reading)))
        else $error("forward-ending result miscomputed");

    first_result_a: assert property (@(posedge clk_in) disable iff (rst_in)
        result_valid_out |-> $past(pair_valid_reg) && $past(take_reading))
        else $error("result without a paired reading");

    disable_gap_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !chop_enable_in && state_reg == BEC_REV |=>
        !fwd_phase_drive_out && fwd_phase_drive_n_out &&
        !rev_phase_drive_out && rev_phase_drive_n_out)
        else $error("disable in reverse skipped the non-overlap gap");

    disabled_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !chop_enable_in && state_reg != BEC_REV && state_reg != BEC_GAP_F |=>
        fwd_phase_drive_out && !fwd_phase_drive_n_out &&
        !rev_phase_drive_out && rev_phase_drive_n_out && !ref_swap_out)
        else $error("disabled state does not hold forward polarity");
endmodule

/* test/bec_bridge_model.sv */
// Behavioural bridge with four excitation switches and a converter front end.
// Assumes the chopper's four drive pins and its reference swap flag.
module bec_bridge_model
    import bec_pkg::*;
#(
    parameter logic signed [READ_W-1:0] OFFSET = 24'sh000003
)
(
    input wire logic clk_in,
    input wire logic fwd_phase_drive_in,
    input wire logic fwd_phase_drive_n_in,
    input wire logic rev_phase_drive_in,
    input wire logic rev_phase_drive_n_in,
    input wire logic ref_swap_in,
    input wire logic signed [READ_W-1:0] signal_in,
    output logic signed [READ_W-1:0] reading_out,
    output logic shoot_out,
    output logic wiring_mismatch_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic q1, q2, q3, q4;
    logic noise_reg = 1'b0;
    // P-channel switches conduct on a low gate, N-channel on a high gate
    assign q1 = !fwd_phase_drive_n_in;
    assign q4 = fwd_phase_drive_in;
    assign q2 = !rev_phase_drive_n_in;
    assign q3 = rev_phase_drive_in;
    assign shoot_out = (q1 | q4) & (q2 | q3);
    // Two-pin wiring: inverters feed the N-channel gates from the complements
    assign wiring_mismatch_out = (q4 != !fwd_phase_drive_n_in) | (q3 != !rev_phase_drive_n_in);
    always @(posedge clk_in) noise_reg <= ~noise_reg;
    // Unpowered bridge gives garbage that changes every cycle, never a stale value
    always_comb begin
        if (q1 & q4) begin
            reading_out = signal_in + OFFSET;
        end else if (q2 & q3) begin
            // Without the reference swap the converter sees a negative reference
            reading_out = ref_swap_in ? OFFSET - signal_in : ~(OFFSET - signal_in);
        end else begin
            reading_out = {READ_W{noise_reg}};
        end
    end
endmodule

/* test/bridge_excitation_chopper_tb.sv */
// Self-checking bench for the excitation chopper and a behavioural bridge.
// Assumes 25 MHz clock and a 25-cycle non-overlap gap per phase change.
module bridge_excitation_chopper_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import bec_pkg::*;
    localparam logic signed [READ_W-1:0] OS = 24'sh000003;
    localparam logic [3:0] P_FWD = 4'h9;
    localparam logic [3:0] P_REV = 4'h6;
    localparam logic [3:0] P_OFF = 4'h5;
    logic clk_in, rst_in, chop_enable_in, conv_done_in;
    logic signed [READ_W-1:0] sig, reading;
    logic fwd, fwd_n, rev, rev_n, swap, valid, shoot, mism;
    logic [READ_W-1:0] result;
    int errors, compares;

    bec_chopper DUT (.clk_in(clk_in), .rst_in(rst_in), .chop_enable_in(chop_enable_in),
        .conv_done_in(conv_done_in), .reading_in(reading), .fwd_phase_drive_out(fwd),
        .fwd_phase_drive_n_out(fwd_n), .rev_phase_drive_out(rev),
        .rev_phase_drive_n_out(rev_n), .ref_swap_out(swap), .result_out(result),
        .result_valid_out(valid));
    bec_bridge_model #(.OFFSET(OS)) bridge (.clk_in(clk_in), .fwd_phase_drive_in(fwd),
        .fwd_phase_drive_n_in(fwd_n), .rev_phase_drive_in(rev), .rev_phase_drive_n_in(rev_n),
        .ref_swap_in(swap), .signal_in(sig), .reading_out(reading), .shoot_out(shoot),
        .wiring_mismatch_out(mism));

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    function automatic logic [READ_W-1:0] half(input logic signed [READ_W-1:0] a, b);
        logic signed [READ_W:0] d;
        d = {a[READ_W-1], a} - {b[READ_W-1], b};
        return d[READ_W:1];
    endfunction

    task automatic chk(input logic [READ_W-1:0] got, exp, input string msg);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_pins(input logic [3:0] p, input logic sw);
        chk(READ_W'({fwd, fwd_n, rev, rev_n, swap}), READ_W'({p, sw}), "pins");
    endtask

    // One conversion pulse; result checked one edge later
    task automatic conv(input logic signed [READ_W-1:0] s, input logic v,
                        input logic [READ_W-1:0] e);
        @(posedge clk_in);
        sig <= s;
        conv_done_in <= 1'b1;
        @(posedge clk_in);
        conv_done_in <= 1'b0;
        #1;
        chk(READ_W'(valid), READ_W'(v), "valid");
        if (v) chk(result, e, "result");
    endtask

    task automatic gap_walk(input logic [3:0] nxt, input logic sw);
        chk_pins(P_OFF, 1'b0);
        repeat (24) begin
            @(posedge clk_in);
            #1;
            chk_pins(P_OFF, 1'b0);
        end
        @(posedge clk_in);
        #1;
        chk_pins(nxt, sw);
    endtask

    task automatic wait_pins(input logic [3:0] p);
        int n;
        n = 0;
        while ({fwd, fwd_n, rev, rev_n} !== p && n < 60) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk_pins(p, p == P_REV);
    endtask

    task automatic test_reset;
        repeat (5) @(posedge clk_in);
        #1;
        chk_pins(P_FWD, 1'b0);
        chk(READ_W'(valid), '0, "idle valid");
        $display("test reset done");
    endtask

    task automatic test_chop;
        @(posedge clk_in);
        chop_enable_in <= 1'b1;
        @(posedge clk_in);
        #1;
        chk_pins(P_FWD, 1'b0);
        conv(24'sh000005, 1'b0, '0);
        gap_walk(P_REV, 1'b1);
        conv(24'sh000004, 1'b1, half(24'sh000005 + OS, OS - 24'sh000004));
        gap_walk(P_FWD, 1'b0);
        conv(-24'sh000007, 1'b1, half(OS - 24'sh000007, OS - 24'sh000004));
        gap_walk(P_REV, 1'b1);
        $display("test chop done");
    endtask

    task automatic test_gap_drop;
        conv(24'sh000002, 1'b1, half(OS - 24'sh000007, OS - 24'sh000002));
        repeat (4) @(posedge clk_in);
        conv(24'sh000009, 1'b0, '0);
        wait_pins(P_FWD);
        conv(24'sh000003, 1'b0, '0);
        wait_pins(P_REV);
        conv(24'sh000001, 1'b1, half(24'sh000003 + OS, OS - 24'sh000001));
        $display("test gap drop done");
    endtask

    task automatic test_disable;
        // The last reading was reverse, so one forward reading completes a pair and gives a result
        wait_pins(P_FWD);
        conv(24'sh000008, 1'b1, half(24'sh000008 + OS, OS - 24'sh000001));
        wait_pins(P_REV);
        @(posedge clk_in);
        chop_enable_in <= 1'b0;
        @(posedge clk_in);
        #1;
        gap_walk(P_FWD, 1'b0);
        conv(24'sh000006, 1'b0, '0);
        @(posedge clk_in);
        chop_enable_in <= 1'b1;
        @(posedge clk_in);
        conv(24'sh000005, 1'b0, '0);
        gap_walk(P_REV, 1'b1);
        conv(24'sh000004, 1'b1, half(24'sh000005 + OS, OS - 24'sh000004));
        $display("test disable done");
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        if (!rst_in && (shoot || mism)) begin
            errors++;
            $display("unexpected at %0t: opposing switches or wiring views disagree", $time);
        end
    end

    initial begin
        #(5000 * 40);
        errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        results();
    end

    initial begin
        errors = 0;
        compares = 0;
        rst_in = 1'b1;
        chop_enable_in = 1'b0;
        conv_done_in = 1'b0;
        sig = '0;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        test_reset();
        test_chop();
        test_gap_drop();
        test_disable();
        results();
    end
endmodule
